// *** aarl_top.sv ***
/*
 * Four-channel ADC result averaging and latching, with channel enables,
 * completion flags, read-only result bytes and an interrupt, behind a
 * classic Wishbone slave.
 * Assumes the converter delivers one sample per conv_valid_i pulse,
 * tagged with its channel, and only while conv_run_o is high.
 */
// Local design decisions: register access over Wishbone and the placing of the registers.
// Behaviour
// (RQ1) Averaging code 0..6 averages 1..64 samples; code 7 is test mode.
// (RQ2) Software changes averaging only while stopped; it resets to zero.
// (RQ3) A channel converts only while its enable bit is one.
// (RQ4) Writing a result sets the channel's done flag and raises interrupt.
// (RQ5) Reading a channel's low result byte clears its done flag.
// (RQ6) While a done flag is set, that channel's result is not overwritten.
// (RQ7) Software reads the high byte before the low byte.
// (RQ8) Result byte registers are read-only; writes are ignored.
// (RQ9) Both result bytes follow the selected result alignment.
// (RQ10) Result bytes sit at fixed indices; their reset content is undefined.

`timescale 1ns/1ps
`default_nettype none

module aarl_top (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [aarl_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [aarl_pkg::DAT_W-1:0] wb_dat_i,
    output logic [aarl_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic conv_valid_i,
    input wire logic [1:0] conv_chan_i,
    input wire logic [aarl_pkg::RES_W-1:0] conv_data_i,
    output logic conv_run_o,
    output logic [aarl_pkg::NCHAN-1:0] chan_convert_en_o,
    output logic irq_o
);

    // Channel count; index 0 is channel A
    localparam int N = aarl_pkg::NCHAN;

    // =========================================================
    // State
    // =========================================================
    logic ack;
    logic [aarl_pkg::DAT_W-1:0] rdata;
    logic next_ack;
    logic [aarl_pkg::DAT_W-1:0] next_rdata;

    logic [N-1:0] chan_convert_en;
    logic [2:0] sample_average_sel;
    logic result_format_sel;
    logic run;
    logic [N-1:0] irq_mask;
    logic [N-1:0] next_chan_convert_en;
    logic [2:0] next_sample_average_sel;
    logic next_result_format_sel;
    logic next_run;
    logic [N-1:0] next_irq_mask;

    // Done flags and the latched result words
    logic [N-1:0] done_flag;
    logic [aarl_pkg::RES_W-1:0] result [N];
    logic [N-1:0] next_done_flag;
    logic [aarl_pkg::RES_W-1:0] next_result [N];

    // Sticky interrupt status, one bit per channel
    logic [N-1:0] irq_status;
    logic [N-1:0] next_irq_status;

    logic access;
    logic wr_strobe;
    logic rd_strobe;
    logic [7:0] idx;
    logic [N-1:0] low_read;
    logic [N-1:0] result_load;
    logic [N-1:0] avg_done;
    logic [aarl_pkg::RES_W-1:0] avg_result [N];
    logic [7:0] high_byte [N];
    logic [7:0] low_byte [N];

    // A request is taken once: ack high blocks a second take of it
    assign access = wb_cyc_i && wb_stb_i && !ack;
    // Control fields all sit in byte lane 0
    assign wr_strobe = access && wb_we_i && wb_sel_i[0];
    assign rd_strobe = access && !wb_we_i;
    // Register index; the two low address bits are ignored
    assign idx = wb_adr_i[aarl_pkg::ADR_W-1:2];

    // =========================================================
    // Per-channel averaging, latching and byte formatting
    // =========================================================
    // One averager and one result latch per channel
    for (genvar ch = 0; ch < N; ch++) begin : g_chan
        aarl_avg_if avg_bus ();
        // Index of this channel's low result byte
        logic [7:0] low_idx;

        always_comb begin
            unique case (ch)
                0: low_idx = aarl_pkg::IDX_A_LOW;
                1: low_idx = aarl_pkg::IDX_B_LOW;
                2: low_idx = aarl_pkg::IDX_C_LOW;
                default: low_idx = aarl_pkg::IDX_D_LOW;
            endcase
        end

        // Samples of a disabled channel never reach its averager
        assign avg_bus.sample_vld = conv_valid_i && run &&
            chan_convert_en[ch] && (conv_chan_i == 2'(ch)); // [RQ3]
        assign avg_bus.sample = conv_data_i;
        assign avg_bus.avg_sel = sample_average_sel; // [RQ1]
        // Stopping or disabling a channel drops its partial average
        assign avg_bus.restart = !run || !chan_convert_en[ch];
        // One-cycle pulse when an average completes
        assign avg_done[ch] = avg_bus.result_vld;
        assign avg_result[ch] = avg_bus.result;

        aarl_accum aarl_accum_i (
            .mclk_i (mclk_i),
            .reset_i (reset_i),
            .avg (avg_bus.accum)
        );

        // Only the low byte read frees the channel
        assign low_read[ch] = rd_strobe && (idx == low_idx); // [RQ5]
        // A held result blocks new results while the flag is set; a blocked one is lost
        assign result_load[ch] = avg_done[ch] && !done_flag[ch]; // [RQ6]

        // Alignment applies at read time, so a format change needs no reload
        always_comb begin
            if (result_format_sel) begin // [RQ9]
                high_byte[ch] = result[ch][11:4];
                low_byte[ch] = {result[ch][3:0], 4'h0};
            end else begin
                high_byte[ch] = {4'h0, result[ch][11:8]};
                low_byte[ch] = result[ch][7:0];
            end
        end
    end

    // =========================================================
    // Flags and result storage
    // =========================================================
    // A low read during a blocked load clears the flag; that result is lost
    always_comb begin
        next_done_flag = done_flag;
        next_result = result;
        for (int i = 0; i < N; i++) begin
            if (low_read[i]) begin
                next_done_flag[i] = 1'b0; // [RQ5]
            end
            if (result_load[i]) begin
                next_result[i] = avg_result[i]; // [RQ4]
                next_done_flag[i] = 1'b1; // [RQ4]
            end
        end
    end

    // Result words keep no reset value
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            done_flag <= '0;
        end else begin
            done_flag <= next_done_flag;
        end
        result <= next_result; // [RQ10]
    end

    // =========================================================
    // Software-written control
    // =========================================================
    always_comb begin
        next_chan_convert_en = chan_convert_en;
        next_sample_average_sel = sample_average_sel;
        next_result_format_sel = result_format_sel;
        next_run = run;
        next_irq_mask = irq_mask;
        // Done flags and result bytes take no write data [RQ8]
        if (wr_strobe) begin
            unique case (idx)
                aarl_pkg::IDX_CHAN_CTRL: begin
                    for (int i = 0; i < N; i++) begin
                        next_chan_convert_en[i] =
                            wb_dat_i[aarl_pkg::EN_TOP-i]; // [RQ3]
                    end
                end
                aarl_pkg::IDX_CONV_CFG: begin
                    // Averaging code should change only while stopped
                    next_sample_average_sel =
                        wb_dat_i[aarl_pkg::CFG_AVG_LSB +: 3]; // [RQ1]
                    next_result_format_sel =
                        wb_dat_i[aarl_pkg::CFG_FMT_BIT];
                    next_run = wb_dat_i[aarl_pkg::CFG_RUN_BIT];
                end
                aarl_pkg::IDX_IRQ_MASK: begin
                    next_irq_mask = wb_dat_i[N-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Control comes out of reset stopped, disabled and fully masked
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            chan_convert_en <= aarl_pkg::RST_CHAN_EN;
            sample_average_sel <= aarl_pkg::RST_AVG; // [RQ2]
            result_format_sel <= aarl_pkg::RST_FMT;
            run <= aarl_pkg::RST_RUN;
            irq_mask <= aarl_pkg::RST_IRQ_MASK;
        end else begin
            chan_convert_en <= next_chan_convert_en;
            sample_average_sel <= next_sample_average_sel;
            result_format_sel <= next_result_format_sel;
            run <= next_run;
            irq_mask <= next_irq_mask;
        end
    end

    // =========================================================
    // Interrupt status, write one to clear, set wins
    // =========================================================
    always_comb begin
        next_irq_status = irq_status;
        if (wr_strobe && idx == aarl_pkg::IDX_IRQ_STATUS) begin
            next_irq_status = irq_status & ~wb_dat_i[N-1:0];
        end
        // Set after clear, so a new result in the clearing cycle survives
        next_irq_status = next_irq_status | result_load; // [RQ4]
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Level output: high while any unmasked status bit is set
    assign irq_o = |(irq_status & irq_mask); // [RQ4]

    // =========================================================
    // Wishbone answer: ack one cycle after the request
    // =========================================================
    always_comb begin
        // Read data is captured at the taking edge and stands with ack
        next_ack = access;
        next_rdata = rdata;
        if (rd_strobe) begin
            // Unmapped indices read as zero
            next_rdata = '0;
            unique case (idx)
                aarl_pkg::IDX_CHAN_CTRL: begin
                    for (int i = 0; i < N; i++) begin
                        next_rdata[aarl_pkg::EN_TOP-i] = chan_convert_en[i];
                        next_rdata[aarl_pkg::FLAG_TOP-i] = done_flag[i];
                    end
                end
                aarl_pkg::IDX_CONV_CFG: begin
                    next_rdata[aarl_pkg::CFG_AVG_LSB +: 3] =
                        sample_average_sel;
                    next_rdata[aarl_pkg::CFG_FMT_BIT] = result_format_sel;
                    next_rdata[aarl_pkg::CFG_RUN_BIT] = run;
                end
                aarl_pkg::IDX_IRQ_STATUS: next_rdata[N-1:0] = irq_status;
                aarl_pkg::IDX_IRQ_MASK: next_rdata[N-1:0] = irq_mask;
                aarl_pkg::IDX_A_LOW: next_rdata[7:0] = low_byte[0];
                aarl_pkg::IDX_A_HIGH: next_rdata[7:0] = high_byte[0];
                aarl_pkg::IDX_B_LOW: next_rdata[7:0] = low_byte[1];
                aarl_pkg::IDX_B_HIGH: next_rdata[7:0] = high_byte[1];
                aarl_pkg::IDX_C_LOW: next_rdata[7:0] = low_byte[2];
                aarl_pkg::IDX_C_HIGH: next_rdata[7:0] = high_byte[2];
                aarl_pkg::IDX_D_LOW: next_rdata[7:0] = low_byte[3];
                aarl_pkg::IDX_D_HIGH: next_rdata[7:0] = high_byte[3];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ack <= 1'b0;
            rdata <= '0;
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // Bus and converter outputs come straight from registers
    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign conv_run_o = run;
    assign chan_convert_en_o = chan_convert_en;

endmodule : aarl_top

`default_nettype wire

// *** aarl_pkg.sv ***
/*
 * Constants for the ADC averaging and result latch block: register
 * indices, field positions, reset values and widths.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
`default_nettype none

package aarl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CHAN_CTRL = 8'hb0;
    localparam logic [7:0] IDX_CONV_CFG = 8'hb1;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hb2;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hb3;
    localparam logic [7:0] IDX_A_LOW = 8'hba;
    localparam logic [7:0] IDX_A_HIGH = 8'hbb;
    localparam logic [7:0] IDX_B_LOW = 8'hbc;
    localparam logic [7:0] IDX_B_HIGH = 8'hbd;
    localparam logic [7:0] IDX_C_LOW = 8'hbe;
    localparam logic [7:0] IDX_C_HIGH = 8'hbf;
    localparam logic [7:0] IDX_D_LOW = 8'haa;
    localparam logic [7:0] IDX_D_HIGH = 8'hab;

    localparam int ADR_W = 10;
    localparam int DAT_W = 32;
    localparam int NCHAN = 4;
    localparam int RES_W = 12;
    localparam int SUM_W = 18;
    localparam int CNT_W = 7;

    // Channel control: enable of channel i at EN_TOP-i, flag at FLAG_TOP-i
    localparam int EN_TOP = 7;
    localparam int FLAG_TOP = 3;

    // Converter configuration fields
    localparam int CFG_AVG_LSB = 0;
    localparam int CFG_FMT_BIT = 3;
    localparam int CFG_RUN_BIT = 4;

    localparam logic [3:0] RST_CHAN_EN = 4'h0;
    localparam logic [2:0] RST_AVG = 3'h0;
    localparam logic RST_FMT = 1'b0;
    localparam logic RST_RUN = 1'b0;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;

    localparam logic [2:0] AVG_TEST = 3'h7;

endpackage : aarl_pkg

`default_nettype wire

// *** aarl_avg_if.sv ***
/*
 * Link between the register block and one channel's averager.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface aarl_avg_if;
    logic sample_vld;
    logic [aarl_pkg::RES_W-1:0] sample;
    logic [2:0] avg_sel;
    logic restart;
    logic result_vld;
    logic [aarl_pkg::RES_W-1:0] result;

    modport owner (
        output sample_vld, sample, avg_sel, restart,
        input result_vld, result
    );
    modport accum (
        input sample_vld, sample, avg_sel, restart,
        output result_vld, result
    );
endinterface : aarl_avg_if

`default_nettype wire

// *** aarl_accum.sv ***
/*
 * Averager for one channel: sums 2**avg_sel samples, one for test code 7, then
 * reports the sum shifted right by avg_sel, by zero for code 7, as a one-cycle result.
 * Assumes restart is held while the converter is stopped.
 */
`timescale 1ns/1ps
`default_nettype none

module aarl_accum (
    input wire logic mclk_i,
    input wire logic reset_i,
    aarl_avg_if.accum avg
);

    logic [aarl_pkg::SUM_W-1:0] sum;
    logic [aarl_pkg::CNT_W-1:0] cnt;
    logic result_vld;
    logic [aarl_pkg::RES_W-1:0] result;
    logic [aarl_pkg::SUM_W-1:0] next_sum;
    logic [aarl_pkg::CNT_W-1:0] next_cnt;
    logic next_result_vld;
    logic [aarl_pkg::RES_W-1:0] next_result;
    logic [aarl_pkg::SUM_W-1:0] total;
    logic [aarl_pkg::CNT_W-1:0] target;
    logic [2:0] shift;

    // =========================================================
    // Averaging
    // =========================================================
    always_comb begin
        // Test mode code behaves as single sample
        shift = (avg.avg_sel == aarl_pkg::AVG_TEST) ? 3'h0 : avg.avg_sel;
        target = aarl_pkg::CNT_W'(1) << shift; // [RQ1]
        total = sum + aarl_pkg::SUM_W'(avg.sample);
        next_sum = sum;
        next_cnt = cnt;
        next_result_vld = 1'b0;
        next_result = result;
        if (avg.restart) begin
            next_sum = '0;
            next_cnt = '0;
        end else if (avg.sample_vld) begin
            if (cnt + 7'h01 == target) begin
                next_result_vld = 1'b1;
                next_result = aarl_pkg::RES_W'(total >> shift); // [RQ1]
                next_sum = '0;
                next_cnt = '0;
            end else begin
                next_sum = total;
                next_cnt = cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sum <= '0;
            cnt <= '0;
            result_vld <= 1'b0;
            result <= '0;
        end else begin
            sum <= next_sum;
            cnt <= next_cnt;
            result_vld <= next_result_vld;
            result <= next_result;
        end
    end

    assign avg.result_vld = result_vld;
    assign avg.result = result;

endmodule : aarl_accum

`default_nettype wire

// *** aarl_top_properties.sv ***
/* Checker for the aarl_top bus, enables, run and interrupt outputs.
   Assumes it is bound onto aarl_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none

module aarl_top_chk (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [aarl_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [aarl_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic [aarl_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic conv_valid_i,
    input wire logic conv_run_o,
    input wire logic [aarl_pkg::NCHAN-1:0] chan_convert_en_o,
    input wire logic irq_o
);
    // ====================
    // Decoded requests
    logic take;
    logic wr;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_mask;
    logic unmapped;
    logic [7:0] idx;
    logic [3:0] en_req;
    logic run_req;
    assign idx = wb_adr_i[9:2];
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = take && wb_we_i && wb_sel_i[0];
    assign wr_ctrl = wr && idx == aarl_pkg::IDX_CHAN_CTRL;
    assign wr_cfg = wr && idx == aarl_pkg::IDX_CONV_CFG;
    assign wr_mask = wr && idx == aarl_pkg::IDX_IRQ_MASK;
    assign unmapped = !(idx inside {[8'hb0:8'hb3], [8'hba:8'hbf],
        8'haa, 8'hab});
    assign en_req = {wb_dat_i[4], wb_dat_i[5], wb_dat_i[6], wb_dat_i[7]};
    assign run_req = wb_dat_i[aarl_pkg::CFG_RUN_BIT];

    // ====================
    // Properties
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_ack; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack)
        else $error("ack is not one pulse after a request");
    property p_unmapped; take && !wb_we_i && unmapped |=> wb_dat_o == '0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero data");
    property p_en; wr_ctrl |=> chan_convert_en_o == $past(en_req); endproperty
    a_en: assert property (p_en)
        else $error("channel enables do not follow the write");
    property p_en_hold; $changed(chan_convert_en_o) |-> $past(wr_ctrl);
    endproperty
    a_en_hold: assert property (p_en_hold)
        else $error("channel enables changed without a write");
    property p_run; wr_cfg |=> conv_run_o == $past(run_req); endproperty
    a_run: assert property (p_run)
        else $error("run output does not follow the write");
    property p_irq_cause;
        $rose(irq_o) |-> $past(conv_valid_i, 2) || $past(wr_mask);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt rose without a result or mask write");
    property p_irq_mask; wr_mask && wb_dat_i[3:0] == 4'h0 |=> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt high with all sources masked");
    property p_reset;
        $fell(reset_i) |-> !wb_ack_o && !conv_run_o && !irq_o
            && chan_convert_en_o == 4'h0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not cleared by reset");
endmodule : aarl_top_chk

bind aarl_top aarl_top_chk aarl_top_chk_i (.mclk_i(mclk_i),
    .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .conv_valid_i(conv_valid_i), .conv_run_o(conv_run_o),
    .chan_convert_en_o(chan_convert_en_o), .irq_o(irq_o));

`default_nettype wire

// *** tb_adc_averaging_result_latch.sv ***
/* Self-checking bench for aarl_top over classic Wishbone.
   Assumes aarl_pkg and the design files are compiled first. */
`timescale 1ns/1ps
`default_nettype none

module tb_adc_averaging_result_latch;
    // ====================
    // Stimulus and design
    logic mclk_i = 1'h0;
    logic reset_i = 1'h1;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [9:0] wb_adr_i = 10'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic conv_valid_i = 1'h0;
    logic [1:0] conv_chan_i = 2'h0;
    logic [11:0] conv_data_i = 12'h0;
    logic conv_run_o;
    logic [3:0] chan_convert_en_o;
    logic irq_o;
    int bad_count = 0;
    int total_checks = 0;
    int s;
    logic [11:0] r;
    logic [7:0] lo_idx [4] = '{8'hba, 8'hbc, 8'hbe, 8'haa};

    always #12.5 mclk_i = ~mclk_i;

    aarl_top aarl_top_i (.mclk_i(mclk_i), .reset_i(reset_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .conv_valid_i(conv_valid_i), .conv_chan_i(conv_chan_i),
        .conv_data_i(conv_data_i), .conv_run_o(conv_run_o),
        .chan_convert_en_o(chan_convert_en_o), .irq_o(irq_o));

    // ====================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic [7:0] idx, input logic we,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        // Hold the request until ack is seen high at a rising edge
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        chk("ack", 32'h1, {31'h0, wb_ack_o});
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(idx, 1'h1, {24'h0, d}, q);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(idx, 1'h0, 32'h0, q);
        chk($sformatf("reg %h", idx), {24'h0, e}, q);
    endtask : rd

    // One sample; the result lands one edge after it is taken
    task automatic smp(input logic [1:0] ch, input logic [11:0] d);
        @(posedge mclk_i);
        conv_valid_i <= 1'h1;
        conv_chan_i <= ch;
        conv_data_i <= d;
        @(posedge mclk_i);
        conv_valid_i <= 1'h0;
        repeat (2) @(posedge mclk_i);
    endtask : smp

    task automatic res(input int ch, input logic [11:0] v, input logic f);
        rd(lo_idx[ch] + 8'h1, f ? v[11:4] : {4'h0, v[11:8]});
        rd(lo_idx[ch], f ? {v[3:0], 4'h0} : v[7:0]);
    endtask : res

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // ====================
    // Tests
    initial begin
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'h0;
        for (int i = 0; i < 4; i++) rd(8'hb0 + 8'(i), 8'h0);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h0);
        wr(8'hb0, 8'hff);
        rd(8'hb0, 8'hf0);
        chk("enables", 32'hf, {28'h0, chan_convert_en_o});
        wr(8'hb0, 8'ha0);
        chk("enables", 32'h5, {28'h0, chan_convert_en_o});
        wr(8'hb3, 8'h0f);
        smp(2'h0, 12'h111);
        wr(8'hb1, 8'h10);
        chk("run", 32'h1, {31'h0, conv_run_o});
        smp(2'h1, 12'h222);
        rd(8'hb0, 8'ha0);
        chk("irq", 32'h0, {31'h0, irq_o});
        wr(8'hb0, 8'hf0);
        for (int c = 0; c < 4; c++) smp(2'(c), 12'h5a0 + 12'(c));
        rd(8'hb0, 8'hff);
        rd(8'hb2, 8'h0f);
        chk("irq", 32'h1, {31'h0, irq_o});
        smp(2'h0, 12'h123);
        wr(8'hba, 8'h00);
        wr(8'hbb, 8'h00);
        rd(8'hb0, 8'hff);
        rd(8'hbb, 8'h05);
        rd(8'hb0, 8'hff);
        for (int c = 0; c < 4; c++) res(c, 12'h5a0 + 12'(c), 1'h0);
        rd(8'hb0, 8'hf0);
        wr(8'hb3, 8'h00);
        chk("irq", 32'h0, {31'h0, irq_o});
        wr(8'hb3, 8'h0f);
        chk("irq", 32'h1, {31'h0, irq_o});
        wr(8'hb2, 8'h0f);
        rd(8'hb2, 8'h00);
        chk("irq", 32'h0, {31'h0, irq_o});
        wr(8'hb1, 8'h18);
        smp(2'h3, 12'habc);
        res(3, 12'habc, 1'h1);
        for (int k = 0; k < 8; k++) begin
            wr(8'hb1, 8'h00);
            chk("run", 32'h0, {31'h0, conv_run_o});
            wr(8'hb1, 8'h10 | 8'(k));
            s = 0;
            for (int i = 0; i < (k == 7 ? 1 : 1 << k); i++) begin
                smp(2'h2, 12'h400 + 12'(i * 31));
                s += 1024 + i * 31;
            end
            r = 12'(s >> (k == 7 ? 0 : k));
            res(2, r, 1'h0);
        end
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        wrap_up();
    end
endmodule : tb_adc_averaging_result_latch

`default_nettype wire
